// ---- src/event_latch_bank.v ----
// Bank of sticky event flags with per-bit set and clear, set winning
`timescale 1ns/1ps
`default_nettype none
module event_latch_bank #(
	parameter WIDTH = 8
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] set_bits,
	input wire [WIDTH-1:0] clear_bits,
	output wire [WIDTH-1:0] flags
);

	genvar i;

	// One flag per bit, each in its own register; a set in the clearing cycle keeps the flag
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
			reg flag_r;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_r <= 1'b0;
				end else if (set_bits[i]) begin
					flag_r <= 1'b1;
				end else if (clear_bits[i]) begin
					flag_r <= 1'b0;
				end
			end
			assign flags[i] = flag_r;
		end
	endgenerate

endmodule // event_latch_bank
`default_nettype wire

// ---- src/framer_event_regs.vh ----
// Register indices, field positions, reset values and counts of the event block
`ifndef FRAMER_EVENT_REGS_VH
`define FRAMER_EVENT_REGS_VH

// Register indices; byte address is four times the index
`define FRAME_EVT_STATUS_IDX 8'h1C
`define FRAME_EVT_MASK_IDX 8'h1D
`define ES_STATUS_IDX 8'h1E
`define ES_MASK_IDX 8'h1F
`define HDLC_ONE_STATUS_IDX 8'h20
`define HDLC_ONE_MASK_IDX 8'h21
`define HDLC_TWO_STATUS_IDX 8'h22
`define HDLC_TWO_MASK_IDX 8'h23
`define LINK_STATUS_IDX 8'h24
`define LINK_MASK_IDX 8'h25
`define HDLC_EVENT_INFO_IDX 8'h2D
`define HDLC_ONE_INFO_IDX 8'h2E
`define HDLC_TWO_INFO_IDX 8'h2F
`define LINK_MATCH_ONE_IDX 8'h40
`define LINK_MATCH_TWO_IDX 8'h41

// Reset values
`define REG_RESET 8'h00
`define MATCH_RESET 8'h00

// Elastic store status fields
`define ES_TX_FULL_BIT 5
`define ES_TX_EMPTY_BIT 4
`define ES_TX_SLIP_BIT 3
`define ES_RX_FULL_BIT 2
`define ES_RX_EMPTY_BIT 1
`define ES_RX_SLIP_BIT 0

// HDLC status fields
`define HS_MSG_DONE_BIT 6
`define HS_PKT_END_BIT 5
`define HS_PKT_START_BIT 4
`define HS_COND_LSB 0

// Packet state codes
`define PKT_IN_PROGRESS 3'h0
`define PKT_GOOD 3'h1
`define PKT_CRC_ERROR 3'h2
`define PKT_ABORT 3'h3
`define PKT_OVERRUN 3'h4

// Data link timing counts, in link bits
`define LINK_CLEAR_BITS 5'h1E
`define LINK_ABORT_ONES 4'h8

`endif

// ---- src/framer_event_status_masks.v ----
// Framer status, information and mask registers with interrupt request over APB
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "framer_event_regs.vh"
module framer_event_status_masks #(
	parameter ADDR_W = 12
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq_r,
	output reg [1:0] tx_abort_send_r,
	input wire tx_multiframe_evt,
	input wire tx_align_frame_evt,
	input wire rx_multiframe_evt,
	input wire rx_crc_multiframe_evt,
	input wire rx_align_frame_evt,
	input wire tx_es_full,
	input wire tx_es_empty,
	input wire rx_es_full,
	input wire rx_es_empty,
	input wire [1:0] tx_message_done,
	input wire [1:0] rx_packet_end,
	input wire [1:0] rx_packet_start,
	input wire [1:0] rx_fifo_above_high,
	input wire [1:0] rx_fifo_has_data,
	input wire [1:0] tx_fifo_below_low,
	input wire [1:0] tx_fifo_has_room,
	input wire [1:0] tx_fifo_empty_live,
	input wire [1:0] tx_fifo_full_live,
	input wire [1:0] rx_fifo_empty_live,
	input wire [1:0] rx_fifo_read,
	input wire [2:0] rx_packet_state_one,
	input wire [2:0] rx_packet_state_two,
	input wire [1:0] tx_fifo_ran_dry,
	input wire [1:0] rx_first_byte_next,
	input wire link_bit_valid,
	input wire link_bit_data,
	input wire link_rx_buf_full,
	input wire link_tx_buf_empty,
	input wire link_rx_byte_valid,
	input wire [7:0] link_rx_byte,
	input wire code_change_evt
);

	// Bus decode
	reg idx_known;
	reg [7:0] rd_val;
	wire [7:0] reg_idx = paddr[9:2];
	wire addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
	wire setup_ph = psel && !penable;
	wire access_done = psel && penable && pready;
	wire wr_done = access_done && pwrite && !pslverr && pstrb[0];
	wire rd_done = access_done && !pwrite && !pslverr;

	// Software registers
	reg [4:0] frame_mask_r;
	reg [5:0] es_mask_r;
	reg [6:0] hdlc_one_mask_r;
	reg [6:0] hdlc_two_mask_r;
	reg [5:0] link_mask_r;
	reg [7:0] link_match_one_r;
	reg [7:0] link_match_two_r;

	// Mask and match register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_mask_r <= 5'h00;
			es_mask_r <= 6'h00;
			hdlc_one_mask_r <= 7'h00;
			hdlc_two_mask_r <= 7'h00;
			link_mask_r <= 6'h00;
			link_match_one_r <= `MATCH_RESET;
			link_match_two_r <= `MATCH_RESET;
		end else if (wr_done) begin
			case (reg_idx)
				`FRAME_EVT_MASK_IDX: frame_mask_r <= pwdata[4:0];
				`ES_MASK_IDX: es_mask_r <= pwdata[5:0];
				`HDLC_ONE_MASK_IDX: hdlc_one_mask_r <= pwdata[6:0];
				`HDLC_TWO_MASK_IDX: hdlc_two_mask_r <= pwdata[6:0];
				`LINK_MASK_IDX: link_mask_r <= pwdata[5:0];
				`LINK_MATCH_ONE_IDX: link_match_one_r <= pwdata[7:0];
				`LINK_MATCH_TWO_IDX: link_match_two_r <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Clear strobes: only bits actually returned by the read are cleared, except that an HDLC status read clears all four rise-pending bits
	wire rd_frame = rd_done && (reg_idx == `FRAME_EVT_STATUS_IDX);
	wire rd_es = rd_done && (reg_idx == `ES_STATUS_IDX);
	wire rd_h1 = rd_done && (reg_idx == `HDLC_ONE_STATUS_IDX);
	wire rd_h2 = rd_done && (reg_idx == `HDLC_TWO_STATUS_IDX);
	wire rd_link = rd_done && (reg_idx == `LINK_STATUS_IDX);
	wire rd_info = rd_done && (reg_idx == `HDLC_EVENT_INFO_IDX);

	// Frame event flags
	wire [4:0] frame_set;
	wire [4:0] frame_flags;
	assign frame_set = {tx_multiframe_evt, tx_align_frame_evt, rx_multiframe_evt,
		rx_crc_multiframe_evt, rx_align_frame_evt};

	// Elastic store flags
	wire [5:0] es_set;
	wire [5:0] es_flags;
	assign es_set[`ES_TX_FULL_BIT] = tx_es_full;
	assign es_set[`ES_TX_EMPTY_BIT] = tx_es_empty;
	assign es_set[`ES_TX_SLIP_BIT] = tx_es_full | tx_es_empty;
	assign es_set[`ES_RX_FULL_BIT] = rx_es_full;
	assign es_set[`ES_RX_EMPTY_BIT] = rx_es_empty;
	assign es_set[`ES_RX_SLIP_BIT] = rx_es_full | rx_es_empty;

	// HDLC event flags, three per controller, clear on read
	wire [2:0] h1_set;
	wire [2:0] h2_set;
	wire [2:0] h1_evt;
	wire [2:0] h2_evt;
	assign h1_set = {tx_message_done[0], rx_packet_end[0], rx_packet_start[0]};
	assign h2_set = {tx_message_done[1], rx_packet_end[1], rx_packet_start[1]};

	wire [3:0] h1_cond = {rx_fifo_above_high[0], rx_fifo_has_data[0], tx_fifo_below_low[0],
		tx_fifo_has_room[0]};
	wire [3:0] h2_cond = {rx_fifo_above_high[1], rx_fifo_has_data[1], tx_fifo_below_low[1],
		tx_fifo_has_room[1]};

	// Previous condition levels, abort pulse and match compare, one cycle each
	reg [3:0] h1_cond_prev_r;
	reg [3:0] h2_cond_prev_r;
	reg match_evt_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h1_cond_prev_r <= 4'h0;
			h2_cond_prev_r <= 4'h0;
			tx_abort_send_r <= 2'h0;
			match_evt_r <= 1'b0;
		end else begin
			h1_cond_prev_r <= h1_cond;
			h2_cond_prev_r <= h2_cond;
			tx_abort_send_r <= tx_fifo_ran_dry;
			match_evt_r <= link_rx_byte_valid &&
				((link_rx_byte == link_match_one_r) || (link_rx_byte == link_match_two_r));
		end
	end

	wire [3:0] h1_rise_pend;
	wire [3:0] h2_rise_pend;

	wire [1:0] udr_flags;

	reg [2:0] pkt_state_one_r;
	reg [2:0] pkt_state_two_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_state_one_r <= `PKT_IN_PROGRESS;
			pkt_state_two_r <= `PKT_IN_PROGRESS;
		end else begin
			if (rx_fifo_read[0]) begin
				pkt_state_one_r <= rx_packet_state_one;
			end
			if (rx_fifo_read[1]) begin
				pkt_state_two_r <= rx_packet_state_two;
			end
		end
	end

	// Data link bit counters: ones run and abort-free run
	reg [3:0] ones_run_r;
	reg [4:0] clear_run_r;
	reg abort_evt_r;
	reg clear_evt_r;
	wire ones_hit;
	assign ones_hit = link_bit_valid && link_bit_data && (ones_run_r == `LINK_ABORT_ONES - 4'h1);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ones_run_r <= 4'h0;
			clear_run_r <= 5'h00;
			abort_evt_r <= 1'b0;
			clear_evt_r <= 1'b0;
		end else begin
			abort_evt_r <= 1'b0;
			clear_evt_r <= 1'b0;
			if (link_bit_valid) begin
				if (!link_bit_data) begin
					ones_run_r <= 4'h0;
				end else if (ones_hit) begin
					ones_run_r <= 4'h0;
					abort_evt_r <= 1'b1;
				end else begin
					ones_run_r <= ones_run_r + 4'h1;
				end
				if (ones_hit) begin
					clear_run_r <= 5'h00;
				end else if (clear_run_r == `LINK_CLEAR_BITS - 5'h01) begin
					clear_run_r <= 5'h00;
					clear_evt_r <= 1'b1;
				end else begin
					clear_run_r <= clear_run_r + 5'h01;
				end
			end
		end
	end

	// Data link flags
	wire [5:0] link_set;
	wire [5:0] link_flags;
	assign link_set = {clear_evt_r, abort_evt_r, link_rx_buf_full, link_tx_buf_empty,
		match_evt_r, code_change_evt};

	// All sticky flags in one bank; a read clears only the bits it returned, plus all four rise-pending bits on an HDLC status read
	wire [32:0] flag_set;
	wire [32:0] flag_clr;
	wire [32:0] flag_q;
	assign flag_set = {link_set, tx_fifo_ran_dry, h2_cond & ~h2_cond_prev_r,
		h1_cond & ~h1_cond_prev_r, h2_set, h1_set, es_set, frame_set};
	assign flag_clr = {prdata[5:0] & {6{rd_link}}, {prdata[3], prdata[1]} & {2{rd_info}},
		{4{rd_h2}}, {4{rd_h1}}, prdata[6:4] & {3{rd_h2}}, prdata[6:4] & {3{rd_h1}},
		prdata[5:0] & {6{rd_es}}, prdata[4:0] & {5{rd_frame}}};
	event_latch_bank #(.WIDTH(33)) u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.set_bits(flag_set),
		.clear_bits(flag_clr),
		.flags(flag_q)
	);
	assign frame_flags = flag_q[4:0];
	assign es_flags = flag_q[10:5];
	assign h1_evt = flag_q[13:11];
	assign h2_evt = flag_q[16:14];
	assign h1_rise_pend = flag_q[20:17];
	assign h2_rise_pend = flag_q[24:21];
	assign udr_flags = flag_q[26:25];
	assign link_flags = flag_q[32:27];

	// Status register views
	wire [7:0] h1_view = {1'b0, h1_evt, h1_cond};
	wire [7:0] h2_view = {1'b0, h2_evt, h2_cond};

	// Read multiplexer
	always @* begin
		rd_val = 8'h00;
		idx_known = 1'b1;
		case (reg_idx)
			`FRAME_EVT_STATUS_IDX: rd_val = {3'h0, frame_flags};
			`FRAME_EVT_MASK_IDX: rd_val = {3'h0, frame_mask_r};
			`ES_STATUS_IDX: rd_val = {2'h0, es_flags};
			`ES_MASK_IDX: rd_val = {2'h0, es_mask_r};
			`HDLC_ONE_STATUS_IDX: rd_val = h1_view;
			`HDLC_ONE_MASK_IDX: rd_val = {1'b0, hdlc_one_mask_r};
			`HDLC_TWO_STATUS_IDX: rd_val = h2_view;
			`HDLC_TWO_MASK_IDX: rd_val = {1'b0, hdlc_two_mask_r};
			`LINK_STATUS_IDX: rd_val = {2'h0, link_flags};
			`LINK_MASK_IDX: rd_val = {2'h0, link_mask_r};
			`HDLC_EVENT_INFO_IDX: rd_val = {4'h0, udr_flags[1], rx_first_byte_next[1],
				udr_flags[0], rx_first_byte_next[0]};
			`HDLC_ONE_INFO_IDX: rd_val = {2'h0, tx_fifo_empty_live[0], tx_fifo_full_live[0],
				rx_fifo_empty_live[0], pkt_state_one_r};
			`HDLC_TWO_INFO_IDX: rd_val = {2'h0, tx_fifo_empty_live[1], tx_fifo_full_live[1],
				rx_fifo_empty_live[1], pkt_state_two_r};
			`LINK_MATCH_ONE_IDX: rd_val = link_match_one_r;
			`LINK_MATCH_TWO_IDX: rd_val = link_match_two_r;
			default: idx_known = 1'b0;
		endcase
	end

	// APB answer: one wait-free access cycle, data snapped at setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			pready <= 1'b1;
			pslverr <= !(addr_ok && idx_known);
			prdata <= (addr_ok && idx_known && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (access_done) begin
				prdata <= 32'h00000000;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (|(frame_flags & frame_mask_r)) |
				(|(es_flags & es_mask_r)) |
				(|(h1_evt & hdlc_one_mask_r[6:4])) |
				(|(h1_rise_pend & hdlc_one_mask_r[3:0])) |
				(|(h2_evt & hdlc_two_mask_r[6:4])) |
				(|(h2_rise_pend & hdlc_two_mask_r[3:0])) |
				(|(link_flags & link_mask_r));
		end
	end

endmodule // framer_event_status_masks
`default_nettype wire

// ---- tb/apb_host.sv ----
// Register bus host model issuing single APB transfers
`timescale 1ns/1ps
`default_nettype none
module apb_host (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [11:0] paddr,
	output var logic [31:0] pwdata
);
	// Bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// Setup, then access held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // apb_host
`default_nettype wire

// ---- tb/event_monitor.sv ----
// Port-level assertions for the framer event register block
`timescale 1ns/1ps
`default_nettype none
module event_monitor #(
	parameter ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] tx_abort_send_r,
	input wire logic [1:0] tx_fifo_ran_dry,
	input wire logic [1:0] rx_first_byte_next,
	input wire logic [1:0] tx_fifo_empty_live,
	input wire logic [1:0] tx_fifo_full_live,
	input wire logic [1:0] rx_fifo_empty_live,
	input wire logic [1:0] tx_message_done,
	input wire logic code_change_evt,
	input wire logic rx_es_full
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Setup phase, and a read setup at one byte address
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rd_s(logic [ADDR_W-1:0] a);
		setup_s ##0 (!pwrite && paddr == a);
	endsequence

	ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	bad_align_a: assert property (setup_s ##0 (paddr[1:0] != 2'b00) |=> pslverr && !prdata)
		else $error("misaligned access not refused");
	abort_follow_a: assert property (tx_fifo_ran_dry[0] |=> tx_abort_send_r[0])
		else $error("abort not sent after underrun");
	abort_cause_a: assert property (tx_abort_send_r[1] |-> $past(tx_fifo_ran_dry[1]))
		else $error("abort sent without underrun");
	info_live_a: assert property (rd_s(12'h0B8) |=> prdata[5:3] ==
		$past({tx_fifo_empty_live[0], tx_fifo_full_live[0], rx_fifo_empty_live[0]}))
		else $error("live fifo flags wrong");
	first_byte_a: assert property (rd_s(12'h0B4) |=> prdata[2] == $past(rx_first_byte_next[1])
		&& prdata[0] == $past(rx_first_byte_next[0]))
		else $error("first byte flags wrong");
	msg_done_a: assert property (tx_message_done[0] ##[1:2] rd_s(12'h080) |=> prdata[6])
		else $error("message done not latched");
	es_rx_full_a: assert property (rx_es_full ##[1:2] rd_s(12'h078) |=> prdata[2] && prdata[0])
		else $error("receive store full not latched");
	code_change_a: assert property (code_change_evt ##[1:2] rd_s(12'h090) |=> prdata[0])
		else $error("code change not latched");
endmodule // event_monitor
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the framer event, status and mask registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq_r, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic lv = '0, ld = '0, lf = '0, le = '0, bv = '0, cc = '0;
	logic [1:0] abrt, md = '0, pe = '0, ps = '0, ah = '0, hd = '0, bl = '0, hr = '0;
	logic [1:0] te = '0, tf = '0, re = '0, rfr = '0, dry = '0, fb = '0;
	logic [4:0] fr = '0;
	logic [3:0] es = '0;
	logic [2:0] s1 = '0, s2 = '0;
	logic [7:0] lb = '0, q;
	int err_total = 0, checks_done = 0, cyc = 0;

	framer_event_status_masks u_framer_event_status_masks (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_r(irq_r),
		.tx_abort_send_r(abrt), .tx_multiframe_evt(fr[4]), .tx_align_frame_evt(fr[3]),
		.rx_multiframe_evt(fr[2]), .rx_crc_multiframe_evt(fr[1]), .rx_align_frame_evt(fr[0]),
		.tx_es_full(es[0]), .tx_es_empty(es[1]), .rx_es_full(es[2]), .rx_es_empty(es[3]),
		.tx_message_done(md), .rx_packet_end(pe), .rx_packet_start(ps),
		.rx_fifo_above_high(ah), .rx_fifo_has_data(hd), .tx_fifo_below_low(bl),
		.tx_fifo_has_room(hr), .tx_fifo_empty_live(te), .tx_fifo_full_live(tf),
		.rx_fifo_empty_live(re), .rx_fifo_read(rfr), .rx_packet_state_one(s1),
		.rx_packet_state_two(s2), .tx_fifo_ran_dry(dry), .rx_first_byte_next(fb),
		.link_bit_valid(lv), .link_bit_data(ld), .link_rx_buf_full(lf),
		.link_tx_buf_empty(le), .link_rx_byte_valid(bv), .link_rx_byte(lb),
		.code_change_evt(cc));
	apb_host u_apb_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// Clock and hang guard
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			final_report;
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		checks_done++;
		if (g !== x) begin
			err_total++;
			$display("unexpected %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] x);
		u_apb_host.xfer(1'b0, {2'b00, i, 2'b00}, 8'h00, q, e);
		chk($sformatf("reg %h", i), x, q);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		u_apb_host.xfer(1'b1, {2'b00, i, 2'b00}, d, q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic lbits(input int n, input logic b);
		repeat (n) begin
			lv <= 1'b1;
			ld <= b;
			tick(1);
		end
		lv <= 1'b0;
	endtask

	task automatic t_regs;
		logic [7:0] st[8] = '{8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24, 8'h2D, 8'h2E, 8'h2F};
		logic [7:0] mk[5] = '{8'h1D, 8'h1F, 8'h21, 8'h23, 8'h25};
		logic [7:0] mv[5] = '{8'h1F, 8'h3F, 8'h7F, 8'h7F, 8'h3F};
		foreach (st[i]) rd(st[i], 8'h00);
		foreach (mk[i]) begin
			rd(mk[i], 8'h00);
			wr(mk[i], 8'hFF);
			rd(mk[i], mv[i]);
		end
		$display("t_regs done");
	endtask
	task automatic t_es;
		logic [7:0] x[4] = '{8'h28, 8'h18, 8'h05, 8'h03};
		for (int i = 0; i < 4; i++) begin
			es <= 4'h1 << i;
			tick(1);
			es <= 4'h0;
			rd(8'h1E, x[i]);
			rd(8'h1E, 8'h00);
		end
		fr <= 5'h1F;
		tick(1);
		fr <= 5'h00;
		rd(8'h1C, 8'h1F);
		wr(8'h1F, 8'h00);
		es <= 4'h1;
		tick(1);
		es <= 4'h0;
		tick(2);
		chk("irq", 8'h00, {7'h00, irq_r});
		wr(8'h1F, 8'h3F);
		tick(2);
		chk("irq", 8'h01, {7'h00, irq_r});
		rd(8'h1E, 8'h28);
		tick(2);
		chk("irq", 8'h00, {7'h00, irq_r});
		$display("t_es done");
	endtask
	// latched events, live conditions, edge interrupt
	task automatic t_hdlc;
		ah <= 2'b01;
		hr <= 2'b01;
		hd <= 2'b10;
		bl <= 2'b10;
		md <= 2'b11;
		pe <= 2'b11;
		ps <= 2'b11;
		tick(1);
		md <= 2'b00;
		pe <= 2'b00;
		ps <= 2'b00;
		rd(8'h20, 8'h79);
		rd(8'h20, 8'h09);
		rd(8'h22, 8'h76);
		rd(8'h22, 8'h06);
		tick(2);
		chk("irq", 8'h00, {7'h00, irq_r});
		ah <= 2'b00;
		tick(3);
		chk("irq", 8'h00, {7'h00, irq_r});
		ah <= 2'b01;
		tick(3);
		chk("irq", 8'h01, {7'h00, irq_r});
		rd(8'h20, 8'h09);
		tick(2);
		chk("irq", 8'h00, {7'h00, irq_r});
		$display("t_hdlc done");
	endtask
	// packet state captured at each fifo read
	task automatic t_info;
		te <= 2'b01;
		re <= 2'b01;
		tf <= 2'b10;
		for (int i = 0; i < 5; i++) begin
			s1 <= 3'(i);
			s2 <= 3'(i);
			rfr <= 2'b11;
			tick(1);
			rfr <= 2'b00;
			s1 <= ~3'(i);
			s2 <= ~3'(i);
			rd(8'h2E, 8'h28 | 8'(i));
			rd(8'h2F, 8'h10 | 8'(i));
		end
		$display("t_info done");
	endtask
	// underrun abort and first byte flags
	task automatic t_under;
		fb <= 2'b01;
		dry <= 2'b11;
		tick(1);
		dry <= 2'b00;
		@(negedge pclk);
		chk("abort", 8'h03, {6'h00, abrt});
		rd(8'h2D, 8'h0B);
		rd(8'h2D, 8'h01);
		fb <= 2'b10;
		rd(8'h2D, 8'h04);
		fb <= 2'b00;
		$display("t_under done");
	endtask
	// link abort, clear count, buffers, match, code change
	task automatic t_link;
		logic [7:0] b[3] = '{8'h55, 8'h7E, 8'h33};
		logic [7:0] x[3] = '{8'h0E, 8'h02, 8'h00};
		lbits(8, 1'b1);
		tick(3);
		rd(8'h24, 8'h10);
		lbits(29, 1'b0);
		tick(3);
		rd(8'h24, 8'h00);
		lbits(1, 1'b0);
		tick(3);
		rd(8'h24, 8'h20);
		cc <= 1'b1;
		tick(1);
		cc <= 1'b0;
		rd(8'h24, 8'h01);
		wr(8'h40, 8'h7E);
		wr(8'h41, 8'h55);
		for (int i = 0; i < 3; i++) begin
			lb <= b[i];
			bv <= 1'b1;
			lf <= (i == 0);
			le <= (i == 0);
			tick(1);
			bv <= 1'b0;
			lf <= 1'b0;
			le <= 1'b0;
			tick(3);
			rd(8'h24, x[i]);
		end
		wr(8'h25, 8'h00);
		cc <= 1'b1;
		tick(1);
		cc <= 1'b0;
		tick(2);
		chk("irq", 8'h00, {7'h00, irq_r});
		wr(8'h25, 8'h01);
		tick(2);
		chk("irq", 8'h01, {7'h00, irq_r});
		rd(8'h24, 8'h01);
		$display("t_link done");
	endtask
	task automatic t_bad;
		u_apb_host.xfer(1'b0, 12'h0C0, 8'h00, q, e);
		chk("unmapped err", 8'h01, {7'h00, e});
		chk("unmapped data", 8'h00, q);
		u_apb_host.xfer(1'b0, 12'h07A, 8'h00, q, e);
		chk("misaligned err", 8'h01, {7'h00, e});
		u_apb_host.xfer(1'b0, 12'h478, 8'h00, q, e);
		chk("high addr err", 8'h01, {7'h00, e});
		wr(8'h1E, 8'hFF);
		rd(8'h1E, 8'h00);
		$display("t_bad done");
	endtask

	// Reset, then the scenarios in order
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_es;
		t_hdlc;
		t_info;
		t_under;
		t_link;
		t_bad;
		final_report;
	end
endmodule // tb_top

bind framer_event_status_masks event_monitor #(.ADDR_W(ADDR_W)) u_event_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_abort_send_r(tx_abort_send_r), .tx_fifo_ran_dry(tx_fifo_ran_dry),
	.rx_first_byte_next(rx_first_byte_next), .tx_fifo_empty_live(tx_fifo_empty_live),
	.tx_fifo_full_live(tx_fifo_full_live), .rx_fifo_empty_live(rx_fifo_empty_live),
	.tx_message_done(tx_message_done), .code_change_evt(code_change_evt),
	.rx_es_full(rx_es_full));
`default_nettype wire
